// file: shared/ocg_pkg.sv
package ocg_pkg;
  // clock and timing base
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // worst-case time from reset release to stable outputs
  localparam int unsigned STARTUP_SETTLE_TIME_US_X10 = 18;
  // longest time rounds down to whole cycles
  localparam int unsigned SETTLE_CYC_DEF =
    (STARTUP_SETTLE_TIME_US_X10 * 100000) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_W = 17;
  // restart delay in output clock periods, inside the two-to-six window
  localparam logic [2:0] START_DLY_CYC = 3'h3;
  // channel count: one single-ended output and four pairs
  localparam int unsigned NUM_CH = 5;
  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_CTRL0 = 4'h0;
  localparam logic [3:0] IDX_CTRL1 = 4'h1;
  localparam logic [3:0] IDX_CTRL2 = 4'h2;
  localparam logic [3:0] IDX_STAT = 4'h8;
  // reset values of the control bytes
  localparam logic [7:0] CTRL0_RST = 8'h04;
  localparam logic [7:0] CTRL1_RST = 8'h05;
  localparam logic [7:0] CTRL2_RST = 8'hC0;
  // enable bit positions
  localparam int unsigned SE_EN_BIT = 2;
  localparam int unsigned PAIR0_EN_BIT = 2;
  localparam int unsigned PAIR1_EN_BIT = 0;
  localparam int unsigned PAIR2_ENABLE_BIT = 7;
  localparam int unsigned PAIR3_ENABLE_BIT = 6;
  // status register field positions
  localparam int unsigned STAT_RUN_LSB = 0;
  localparam int unsigned STAT_SPREAD_BIT = 5;
  localparam int unsigned STAT_SETTLED_BIT = 6;
  // pair output synthesis: phase accumulator, toggles on carry
  localparam int unsigned NCO_W = 16;
  localparam logic [NCO_W-1:0] NCO_INC_NOM = 16'h8000;
  // down spread depth in tenths of a percent, and modulation rate in hertz
  localparam int unsigned SPREAD_PERMILLE = 5;
  localparam int unsigned MOD_FREQ_HZ = 31500;
  localparam logic [NCO_W-1:0] SPREAD_MAX =
    NCO_W'((32768 * SPREAD_PERMILLE) / 1000);
  // one full up-and-down sweep of the offset in clock cycles
  localparam int unsigned MOD_PERIOD_CYC = CLK_HZ / MOD_FREQ_HZ;
  // cycles per offset step, rounded to nearest so the rate stays in its band
  localparam logic [7:0] MOD_STEP_CYC =
    8'((MOD_PERIOD_CYC + int'(SPREAD_MAX)) / (2 * int'(SPREAD_MAX)));
  // ahb encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : ocg_pkg

// file: hw/ocg_gate_top.sv
module ocg_gate_top #(
  parameter int unsigned SETTLE_CYC = ocg_pkg::SETTLE_CYC_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // board-side pins
  input wire logic ref_gate_pin,
  input wire logic [3:0] pair_gate_pin,
  input wire logic spread_select_pin,
  // clock outputs
  output logic ref_clk_out,
  output logic [3:0] pair_outputs_p,
  output logic [3:0] pair_outputs_n
);
  import ocg_pkg::*;

  // overview: one free-running clock feeds every channel; gating only masks
  // the output flops, so the accumulator, the phase bits and the spread sweep
  // never pause, and a restart lines up with the running phase

  // word index of a byte address; out-of-range maps to an unused index
  // any address above the small window decodes to an index with no register,
  // so stray accesses read zero and writes there are dropped
  function automatic logic [3:0] reg_idx(input logic [31:0] a);
    reg_idx = (a[31:6] == 26'h0) ? a[5:2] : 4'hF;
  endfunction : reg_idx

  // control bytes, all bits kept as read/write
  logic [7:0] ctrl0_ff, ctrl1_ff, ctrl2_ff;
  // captured address phase
  logic wr_pend_ff;
  logic [3:0] wr_idx_ff;
  logic [31:0] rdata_ff;
  // synchronisers for pins and enable bits
  logic [NUM_CH-1:0] pin_s1_ff, pin_s2_ff, bit_s1_ff, bit_s2_ff;
  logic spr_s1_ff, spr_s2_ff;
  // startup settle
  logic [SETTLE_W-1:0] settle_cnt_ff;
  logic settled_ff;
  // per-channel output state
  logic [NUM_CH-1:0] phase_ff, run_ff, out_ff, outn_ff;
  logic [2:0] dly_cnt_ff [NUM_CH];
  // pair synthesis
  logic [NCO_W-1:0] nco_ff;
  logic [NCO_W-1:0] spr_ofs_ff;
  logic spr_up_ff;
  logic [7:0] step_cnt_ff;

  // address phase accepted when selected, active and bus ready
  wire addr_ok = hsel & htrans[1] & hready;
  wire [3:0] a_idx = reg_idx(haddr);
  wire wr_take = addr_ok & hwrite & (hsize == HSIZE_WORD);
  wire rd_take = addr_ok & ~hwrite;
  // pending write lands this cycle; forward it to a read of the same word
  wire [7:0] wbyte = hwdata[7:0];
  wire [7:0] c0_now = (wr_pend_ff && wr_idx_ff == IDX_CTRL0) ? wbyte : ctrl0_ff;
  wire [7:0] c1_now = (wr_pend_ff && wr_idx_ff == IDX_CTRL1) ? wbyte : ctrl1_ff;
  wire [7:0] c2_now = (wr_pend_ff && wr_idx_ff == IDX_CTRL2) ? wbyte : ctrl2_ff;

  // enable bits gathered per channel: 0 single-ended, 1..4 pairs 0..3
  wire [NUM_CH-1:0] en_bits = {ctrl2_ff[PAIR3_ENABLE_BIT], ctrl2_ff[PAIR2_ENABLE_BIT],
                               ctrl1_ff[PAIR1_EN_BIT], ctrl1_ff[PAIR0_EN_BIT],
                               ctrl0_ff[SE_EN_BIT]};
  // gate pins assumed actively driven by the board; no pull fallback
  wire [NUM_CH-1:0] pin_bits = {pair_gate_pin, ref_gate_pin};
  // both synchronised levels must be high; either low stops
  wire [NUM_CH-1:0] want = pin_s2_ff & bit_s2_ff & {NUM_CH{settled_ff}};

  // status word read back by software
  // status bits are the synchronised view the gate logic itself uses, so a
  // read shows the state that the outputs follow, not the raw pins
  wire [7:0] stat_byte = {1'b0, settled_ff, spr_s2_ff, run_ff};
  wire [31:0] rd_mux = (a_idx == IDX_CTRL0) ? {24'h0, c0_now} :
                       (a_idx == IDX_CTRL1) ? {24'h0, c1_now} :
                       (a_idx == IDX_CTRL2) ? {24'h0, c2_now} :
                       (a_idx == IDX_STAT) ? {24'h0, stat_byte} : 32'h0;

  // the slave never stalls, so the data phase always follows the address
  // phase by one cycle; a write lands at the end of its data phase, and a read
  // in the very next address phase sees it through the forwarding muxes
  // zero-wait slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;

  // address phase capture
  // the index is captured on every edge; only the pending flag says it is live
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= 4'h0;
    end
    else
    begin
      wr_pend_ff <= wr_take;
      wr_idx_ff <= a_idx;
    end
  end

  // read data registered at the address phase, stands in the data phase
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_ff <= 32'h0;
    else if (rd_take)
      rdata_ff <= rd_mux;
  end

  // control byte writes in the data phase; unmapped words ignore writes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl0_ff <= CTRL0_RST;
      ctrl1_ff <= CTRL1_RST;
      ctrl2_ff <= CTRL2_RST;
    end
    else
    begin
      ctrl0_ff <= c0_now;
      ctrl1_ff <= c1_now;
      ctrl2_ff <= c2_now;
    end
  end

  // two-flop synchronisers; first stage feeds only the second
  // the enable bits live in this clock domain already, but they take the same
  // two stages as the pins so that a pin and its bit changing together reach
  // the gate on the same edge
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      bit_s1_ff <= '0;
      bit_s2_ff <= '0;
      spr_s1_ff <= 1'b0;
      spr_s2_ff <= 1'b0;
    end
    else
    begin
      pin_s1_ff <= pin_bits;
      pin_s2_ff <= pin_s1_ff;
      bit_s1_ff <= en_bits;
      bit_s2_ff <= bit_s1_ff;
      spr_s1_ff <= spread_select_pin;
      spr_s2_ff <= spr_s1_ff;
    end
  end

  // hold every output low until the settle time has passed
  // limitation: the count starts at reset release, so the reference must
  // already be valid then; a late reference shortens the margin one for one
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      settle_cnt_ff <= '0;
      settled_ff <= 1'b0;
    end
    else if (!settled_ff)
    begin
      // settle count is the earliest point; outputs may start no sooner
      settle_cnt_ff <= settle_cnt_ff + SETTLE_W'(1);
      settled_ff <= (settle_cnt_ff >= SETTLE_W'(SETTLE_CYC - 1));
    end
  end

  // triangle modulation of the down-spread offset, 0 to SPREAD_MAX
  wire step_now = (step_cnt_ff == MOD_STEP_CYC - 8'h01);
  wire [NCO_W-1:0] spr_ofs_use = spr_s2_ff ? spr_ofs_ff : '0;
  wire [NCO_W:0] nco_sum = {1'b0, nco_ff} + {1'b0, NCO_INC_NOM - spr_ofs_use};

  // modulation runs always so a spread change takes effect at once, at the sweep's current offset
  // the offset only ever moves by one step, so the pair period changes by a
  // tiny fraction per step; low cycle-to-cycle jitter is bought with a
  // fine sweep of 164 levels, 0 to SPREAD_MAX
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      step_cnt_ff <= 8'h00;
      spr_ofs_ff <= '0;
      spr_up_ff <= 1'b1;
    end
    else
    begin
      step_cnt_ff <= step_now ? 8'h00 : step_cnt_ff + 8'h01;
      if (step_now)
      begin
        // turn around at either end of the sweep
        if (spr_up_ff && spr_ofs_ff == SPREAD_MAX)
          spr_up_ff <= 1'b0;
        else if (!spr_up_ff && spr_ofs_ff == '0)
          spr_up_ff <= 1'b1;
        else
          spr_ofs_ff <= spr_up_ff ? spr_ofs_ff + NCO_W'(1) : spr_ofs_ff - NCO_W'(1);
      end
    end
  end

  // shared accumulator for the pair clocks; it never stops with gating
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      nco_ff <= '0;
    else
      nco_ff <= nco_sum[NCO_W-1:0];
  end

  // toggle ticks: single-ended every clock, pairs on accumulator carry
  wire [NUM_CH-1:0] tick = {{(NUM_CH-1){nco_sum[NCO_W]}}, 1'b1};

  // channel 0 toggles on every clock and runs at half the clock rate; the
  // pairs toggle on accumulator carries and run at a quarter of it, slightly
  // lower while spread is on; every channel shares one gate scheme
  // per-channel gate and output generation
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      // a rising edge is due when the phase is low and a tick arrives
      wire rise_due = tick[g] & ~phase_ff[g];
      wire dly_done = (dly_cnt_ff[g] >= START_DLY_CYC);
      // gate decision only at a rising boundary; no runt or stretch
      wire nxt_run = rise_due ? (want[g] & (run_ff[g] | dly_done)) : run_ff[g];
      wire nxt_phase = tick[g] ? ~phase_ff[g] : phase_ff[g];

      // phase never stops; only the output is masked
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          phase_ff[g] <= 1'b0;
        else
          phase_ff[g] <= nxt_phase;
      end

      // restart waits a fixed count of output periods
      // the count restarts whenever the gate drops before the output has
      // started, so a short glitch on a pin never starts a truncated burst
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          dly_cnt_ff[g] <= 3'h0;
        else if (!want[g] || run_ff[g])
          dly_cnt_ff[g] <= 3'h0;
        else if (rise_due && !dly_done)
          dly_cnt_ff[g] <= dly_cnt_ff[g] + 3'h1;
      end

      // stop lands after the high half ends, so the pulse completes
      // the decision is only taken where the phase turns high, so the last
      // pulse before a stop and the first pulse after a start are both whole
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          run_ff[g] <= 1'b0;
          out_ff[g] <= 1'b0;
          outn_ff[g] <= 1'b0;
        end
        else
        begin
          run_ff[g] <= nxt_run;
          // parked low while stopped, both legs low
          out_ff[g] <= nxt_run & nxt_phase;
          outn_ff[g] <= nxt_run & ~nxt_phase;
        end
      end
    end
  endgenerate

  // the single-ended channel has no complement leg; its n flop is unused and
  // left for the tools to trim
  // drive pins from the output flops
  assign ref_clk_out = out_ff[0];
  assign pair_outputs_p = out_ff[NUM_CH-1:1];
  assign pair_outputs_n = outn_ff[NUM_CH-1:1];
endmodule : ocg_gate_top

// file: test/ocg_gate_monitor.sv
module ocg_gate_monitor #(
  parameter int unsigned SETTLE_CYC = 20
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ref_gate_pin,
  input wire logic [3:0] pair_gate_pin,
  input wire logic ref_clk_out,
  input wire logic [3:0] pair_outputs_p,
  input wire logic [3:0] pair_outputs_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // recent gate history, bit k is the pin k+1 cycles back
  logic [4:0] ref_hist_ff;
  logic [4:0] p0_hist_ff;
  // cycles with every pair gate low, saturating
  logic [4:0] idle_ff;
  // cycles since reset release, saturating so long runs never wrap
  logic [16:0] up_ff;
  // history and span counters
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      ref_hist_ff <= 5'h00;
      p0_hist_ff <= 5'h00;
      idle_ff <= 5'h00;
      up_ff <= 17'h00000;
    end
    else
    begin
      ref_hist_ff <= {ref_hist_ff[3:0], ref_gate_pin};
      p0_hist_ff <= {p0_hist_ff[3:0], pair_gate_pin[0]};
      idle_ff <= (pair_gate_pin != 4'h0) ? 5'h00 : idle_ff + 5'((idle_ff != 5'h1F));
      up_ff <= up_ff + 17'((up_ff != 17'h1FFFF));
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // gate held low long enough to be parked, then raised
  sequence ref_parked_then_raised;
    !ref_gate_pin [*8] ##1 ref_gate_pin;
  endsequence
  chk_ref_needs_pin: assert property (
    $rose(ref_clk_out) |-> ref_hist_ff[4:1] != 4'h0) else $error("ref rose without gate");
  chk_pair_needs_pin: assert property (
    $rose(pair_outputs_p[0]) |-> p0_hist_ff[4:1] != 4'h0) else $error("pair rose without gate");
  chk_ref_stop_low: assert property (
    !ref_gate_pin [*8] |-> !ref_clk_out) else $error("ref not parked low");
  chk_pair_park_low: assert property (
    idle_ff >= 5'h18 |-> (pair_outputs_p | pair_outputs_n) == 4'h0) else $error("pair not parked");
  chk_ref_full_pulse: assert property (
    $rose(ref_clk_out) |=> !ref_clk_out) else $error("ref high pulse stretched");
  chk_ref_start_delay: assert property (
    ref_parked_then_raised |-> !ref_clk_out [*4]) else $error("ref restarted too early");
  chk_legs_exclusive: assert property (
    (pair_outputs_p & pair_outputs_n) == 4'h0) else $error("pair legs both high");
  chk_settle_quiet: assert property (
    up_ff < 17'(SETTLE_CYC) |-> !ref_clk_out && pair_outputs_p == 4'h0) else $error("early clock");
endmodule : ocg_gate_monitor
bind ocg_gate_top ocg_gate_monitor #(.SETTLE_CYC(SETTLE_CYC)) mon_u (.clk, .arst_n,
  .ref_gate_pin, .pair_gate_pin, .ref_clk_out, .pair_outputs_p, .pair_outputs_n);

// file: test/ocg_board_model.sv
module ocg_board_model (
  input wire logic clk,
  input wire logic [4:0] gate_req,
  input wire logic spread_req,
  output logic ref_gate_pin,
  output logic [3:0] pair_gate_pin,
  output logic spread_select_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins carry a driven level from time zero, never left to the pull
  initial {spread_select_pin, pair_gate_pin, ref_gate_pin} = 6'h1F;
  // board logic changes pins just after an edge
  always @(posedge clk)
    {spread_select_pin, pair_gate_pin, ref_gate_pin} <= {spread_req, gate_req};
endmodule : ocg_board_model

// file: test/output_clock_gating_spread_tb.sv
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module output_clock_gating_spread_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ocg_pkg::*;
  // register case: address, byte written, byte read back
  typedef struct packed {logic [31:0] a; logic [7:0] w; logic [7:0] e;} ocg_row_s;
  ocg_row_s rows [5] = '{'{32'h0, 8'hA5, 8'hA5}, '{32'h4, 8'h3C, 8'h3C},
    '{32'h8, 8'h81, 8'h81}, '{32'hC, 8'hFF, 8'h00}, '{32'h40, 8'h12, 8'h00}};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = HTRANS_IDLE;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [4:0] gate_req = 5'h1F;
  logic spread_req = 1'b0;
  logic [3:0] seen;
  wire hreadyout, hresp, ref_gate_pin, spread_select_pin, ref_clk_out;
  wire [31:0] hrdata;
  wire [3:0] pair_gate_pin, pair_outputs_p, pair_outputs_n;
  int num_errors = 0;
  int n_checks = 0;
  int n;
  int c_off;
  int c_on;
  // 50 mhz
  always #10 clk = ~clk;
  ocg_gate_top #(.SETTLE_CYC(20)) dut_u (.clk, .arst_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize(HSIZE_WORD), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .ref_gate_pin, .pair_gate_pin, .spread_select_pin, .ref_clk_out, .pair_outputs_p,
    .pair_outputs_n);
  ocg_board_model board_u (.clk, .gate_req, .spread_req, .ref_gate_pin, .pair_gate_pin,
    .spread_select_pin);
  // one single transfer; read data taken at the data phase edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask : bus
  // read a word and compare it
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(hrdata, e)
    `CHK(hresp, 1'b0)
  endtask : rd
  // board pins change just after an edge
  task automatic drive(input logic [4:0] g, input logic s);
    @(posedge clk);
    gate_req <= g;
    spread_req <= s;
  endtask : drive
  // negedges until ref is seen high, bounded
  task automatic wait_ref(output int k);
    k = 0;
    do begin @(negedge clk); k++; end while (ref_clk_out !== 1'b1 && k < 40);
  endtask : wait_ref
  // rising edges of pair 0 over a fixed span
  task automatic count_p0(output int c);
    logic last;
    c = 0;
    last = pair_outputs_p[0];
    repeat (6400)
    begin
      @(negedge clk);
      c += int'(pair_outputs_p[0] && !last);
      last = pair_outputs_p[0];
    end
  endtask : count_p0
  // which pairs toggle over a dozen cycles
  task automatic watch_pairs;
    seen = 4'h0;
    repeat (12)
    begin
      @(negedge clk);
      seen |= pair_outputs_p;
    end
  endtask : watch_pairs
  task automatic tally_and_finish;
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // watchdog well beyond the expected run
  initial
  begin
    repeat (30000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    rd(32'h0, 32'h04);
    rd(32'h4, 32'h05);
    rd(32'h8, 32'hC0);
    wait_ref(n);
    `CHK(ref_clk_out, 1'b1)
    @(posedge clk);
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].a, {24'h0, rows[i].w});
      rd(rows[i].a, {24'h0, rows[i].e});
    end
    // bits now enable pairs 0 and 2 only, all pins high
    repeat (20) @(negedge clk);
    watch_pairs();
    `CHK(seen, 4'h5)
    // ref pin low: ref parks, pairs keep running
    drive(5'h1E, 1'b0);
    watch_pairs();
    `CHK(ref_clk_out, 1'b0)
    `CHK(seen, 4'h5)
    // pin rises one edge after the request; first edge comes n-2 clocks later
    drive(5'h1F, 1'b0);
    wait_ref(n);
    `CHK(n >= 6 && n <= 14, 1'b1)
    drive(5'h01, 1'b0);
    repeat (30) @(negedge clk);
    `CHK({pair_outputs_p, pair_outputs_n}, 8'h00)
    drive(5'h1F, 1'b0);
    repeat (30) @(negedge clk);
    count_p0(c_off);
    drive(5'h1F, 1'b1);
    repeat (20) @(negedge clk);
    count_p0(c_on);
    `CHK(c_off >= 1599 && c_off <= 1601, 1'b1)
    `CHK(c_on <= 1598, 1'b1)
    `CHK(c_on >= 1590, 1'b1)
    // status: settled, spread on, single-ended with pairs 0 and 2 running
    @(posedge clk);
    rd({26'h0, IDX_STAT, 2'h0}, 32'h6B);
    // mid-run reset: clocks park at once, bytes return to defaults
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({ref_clk_out, pair_outputs_p, pair_outputs_n}, 9'h000)
    arst_n <= 1'b1;
    rd(32'h0, {24'h0, CTRL0_RST});
    wait_ref(n);
    `CHK(n >= 20 && n <= 31, 1'b1)
    @(posedge clk);
    rd(32'h8, {24'h0, CTRL2_RST});
    tally_and_finish();
  end
endmodule : output_clock_gating_spread_tb
